// file: design/ctss_pkg.sv
package ctss_pkg;

  // Source select encodings
  localparam logic [2:0] CTSS_SRC_EXT = 3'h0;
  localparam logic [2:0] CTSS_SRC_SW = 3'h1;
  localparam logic [2:0] CTSS_SRC_PLL = 3'h2;
  localparam logic [2:0] CTSS_SRC_ENC = 3'h3;
  localparam logic [2:0] CTSS_SRC_ONCE = 3'h4;
  localparam int CTSS_NSRC = 5;

  // Source availability masks, bit per source encoding
  localparam logic [4:0] CTSS_AVAIL_BURST = 5'h1B;
  localparam logic [4:0] CTSS_AVAIL_FRAME = 5'h0F;
  localparam logic [4:0] CTSS_AVAIL_EXPEND = 5'h01;

  // Module indices
  localparam int CTSS_MOD_BURST = 0;
  localparam int CTSS_MOD_FRAME = 1;
  localparam int CTSS_MOD_EXPEND = 2;

  // Register offsets (word index on the plain port)
  localparam logic [3:0] CTSS_REG_CTRL0 = 4'h0;
  localparam logic [3:0] CTSS_REG_CTRL1 = 4'h1;
  localparam logic [3:0] CTSS_REG_CTRL2 = 4'h2;
  localparam logic [3:0] CTSS_REG_STEP0 = 4'h4;
  localparam logic [3:0] CTSS_REG_STEP1 = 4'h5;
  localparam logic [3:0] CTSS_REG_STEP2 = 4'h6;
  localparam logic [3:0] CTSS_REG_ERR0 = 4'h8;
  localparam logic [3:0] CTSS_REG_ERR1 = 4'h9;
  localparam logic [3:0] CTSS_REG_ERR2 = 4'hA;
  localparam logic [3:0] CTSS_REG_RATE = 4'hC;
  localparam logic [3:0] CTSS_REG_FIRE = 4'hD;

  // Control register fields
  localparam int CTSS_F_EN = 0;
  localparam int CTSS_F_EDGE = 1;
  localparam int CTSS_F_INV = 2;
  localparam int CTSS_F_SRC_LO = 4;
  localparam int CTSS_F_INP_LO = 8;
  localparam int CTSS_F_AVAIL_LO = 16;
  localparam int CTSS_F_ONCE_DONE = 24;
  localparam int CTSS_F_READY = 25;

  // Reset values
  localparam logic [31:0] CTSS_RATE_RST = 32'h000F4240;

endpackage : ctss_pkg

// file: design/ctss_chan.sv
`timescale 1ns/10ps
`default_nettype none
module ctss_chan
  import ctss_pkg::*;
#(
  parameter int NIN = 4,
  parameter int PW = 32,
  parameter logic [4:0] AVAIL = CTSS_AVAIL_FRAME
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic edge_mode,
  input wire logic invert,
  input wire logic [2:0] src_sel,
  input wire logic [NIN-1:0] ext_sync,
  input wire logic [$clog2(NIN)-1:0] inp_sel,
  input wire logic sw_pulse,
  input wire logic pll_tick,
  input wire logic [PW-1:0] enc_pos,
  input wire logic [PW-1:0] step,
  input wire logic ready,
  input wire logic clr_once,
  output logic fire,
  output logic reject,
  output logic once_done
);

  // Selected external input with polarity applied; history kept on the raw pin
  // so that a change of polarity makes no false edge
  wire ext_raw = ext_sync[inp_sel];
  logic ext_prev_q;
  wire ext_lvl = ext_raw ^ invert;
  wire prev_lvl = ext_prev_q ^ invert;
  wire ext_evt = edge_mode ? (ext_lvl & ~prev_lvl) : ext_lvl;
  logic [PW-1:0] last_pos_q;
  wire [PW-1:0] travel = enc_pos - last_pos_q;
  wire enc_evt = (step != '0) && (travel >= step);
  wire once_evt = !once_done && (enc_pos == step);
  wire src_ok = AVAIL[src_sel];

  // Source selection
  logic evt;
  always_comb begin
    case (src_sel)
      CTSS_SRC_EXT: evt = ext_evt;
      CTSS_SRC_SW: evt = sw_pulse;
      CTSS_SRC_PLL: evt = pll_tick;
      CTSS_SRC_ENC: evt = enc_evt;
      CTSS_SRC_ONCE: evt = once_evt;
      default: evt = 1'b0;
    endcase
  end
  wire act = enable && src_ok && evt;

  // Edge history, encoder reference and one-shot latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_q <= 1'b0;
      last_pos_q <= '0;
      once_done <= 1'b0;
      fire <= 1'b0;
      reject <= 1'b0;
    end else if (ce) begin
      ext_prev_q <= ext_raw;
      fire <= act && ready;
      reject <= act && !ready;
      if (act && src_sel == CTSS_SRC_ENC) begin
        last_pos_q <= enc_pos;
      end else if (!enable || src_sel != CTSS_SRC_ENC) begin
        last_pos_q <= enc_pos;
      end
      if (act && src_sel == CTSS_SRC_ONCE) begin
        once_done <= 1'b1;
      end else if (clr_once) begin
        once_done <= 1'b0;
      end
    end
  end

endmodule : ctss_chan
`default_nettype wire

// file: design/ctss_top.sv
// What this block does
// - Three trigger modules exist: burst begin, exposure begin and exposure finish.
// - Each module has its own enable and, when enabled, takes events from its chosen source.
// - The external source fires on a rising edge or a high level, as configured.
// - An invert option turns that into a falling edge or a low level.
// - The software source fires on the host fire command, which the host must issue.
// - The frequency-multiplier source fires on every multiplier tick.
// - The periodic encoder source fires each time the position advances by the step interval.
// - The single-shot position source fires only the first time position equals the interval.
// - Each module reports to the host which sources it may select.
// - Burst: ext, sw, enc, once; exposure begin: ext, sw, pll, enc; finish: ext only.
// - Events while a module is not ready are ignored and counted in a readable counter, except internal frame starts, which are not counted.
// - With exposure begin disabled, frame starts are made internally at the free-run rate.
`timescale 1ns/10ps
`default_nettype none
module ctss_top
  import ctss_pkg::*;
#(
  parameter int NIN = 4,
  parameter int PW = 32,
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [NIN-1:0] ext_in,
  input wire logic pll_tick,
  input wire logic [PW-1:0] enc_pos,
  input wire logic [2:0] ready,
  output logic [2:0] trig
);

  // Parameter range check
  if (NIN < 2 || NIN > 16 || PW < 2 || PW > 32 || CW < 1 || CW > 32) begin : g_bad_param
    $error("ctss_top: unsupported parameter value");
  end

  localparam int IW = $clog2(NIN);
  localparam logic [4:0] AVAIL [3] = '{CTSS_AVAIL_BURST, CTSS_AVAIL_FRAME, CTSS_AVAIL_EXPEND};

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  logic [1:0] rst_sync_q;
  wire rst_core_n = rst_sync_q[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  logic [NIN-1:0] ext_m_q;
  logic [NIN-1:0] ext_s_q;
  // Two-stage synchroniser for external inputs
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ext_m_q <= '0;
      ext_s_q <= '0;
    end else if (ce) begin
      ext_m_q <= ext_in;
      ext_s_q <= ext_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_ctrl0 = wr && addr == CTSS_REG_CTRL0;
  wire wr_ctrl1 = wr && addr == CTSS_REG_CTRL1;
  wire wr_ctrl2 = wr && addr == CTSS_REG_CTRL2;
  wire wr_step0 = wr && addr == CTSS_REG_STEP0;
  wire wr_step1 = wr && addr == CTSS_REG_STEP1;
  wire wr_step2 = wr && addr == CTSS_REG_STEP2;
  wire wr_rate = wr && addr == CTSS_REG_RATE;
  wire wr_fire = wr && addr == CTSS_REG_FIRE;
  wire [2:0] wr_ctrl = {wr_ctrl2, wr_ctrl1, wr_ctrl0};
  wire [2:0] wr_step = {wr_step2, wr_step1, wr_step0};

  logic [31:0] rate_q;
  logic [31:0] rate_cnt_q;
  logic [2:0] sw_q;
  wire [2:0] trig_d;
  wire [31:0] ctrl_rd [3];
  wire [31:0] step_rd [3];
  wire [31:0] err_rd [3];
  // External input select per module
  logic [IW-1:0] inp_q [3];

  ////////////////////////////////////////////////////////////////////////////////
  // Per-module trigger channels
  for (genvar m = 0; m < 3; m++) begin : g_mod
    logic [7:0] ctrl_q;
    logic [PW-1:0] step_q;
    logic [CW-1:0] err_q;
    logic fire;
    logic reject;
    logic once_done;

    // Control, step interval and rejected event counter
    always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
        ctrl_q <= 8'h00;
        step_q <= '0;
        err_q <= '0;
      end else if (ce) begin
        if (wr_ctrl[m]) begin
          ctrl_q <= wdata[7:0];
        end
        if (wr_step[m]) begin
          step_q <= wdata[PW-1:0];
        end
        if (reject && err_q != '1) begin
          err_q <= err_q + 1'b1;
        end
      end
    end

    ctss_chan #(
      .NIN(NIN),
      .PW(PW),
      .AVAIL(AVAIL[m])
    ) u_chan (
      .clk(clk),
      .rst_n(rst_core_n),
      .ce(ce),
      .enable(ctrl_q[CTSS_F_EN]),
      .edge_mode(ctrl_q[CTSS_F_EDGE]),
      .invert(ctrl_q[CTSS_F_INV]),
      .src_sel(ctrl_q[CTSS_F_SRC_LO+:3]),
      .ext_sync(ext_s_q),
      .inp_sel(inp_q[m]),
      .sw_pulse(sw_q[m]),
      .pll_tick(pll_tick),
      .enc_pos(enc_pos),
      .step(step_q),
      .ready(ready[m]),
      .clr_once(wr_step[m]),
      .fire(fire),
      .reject(reject),
      .once_done(once_done)
    );

    // Readback: control, availability, one-shot state, ready
    assign ctrl_rd[m] = {6'h00, ready[m], once_done, 3'h0, AVAIL[m], 8'(inp_q[m]), ctrl_q};
    assign step_rd[m] = 32'(step_q);
    assign err_rd[m] = 32'(err_q);
    assign trig_d[m] = fire;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // External input select per module
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      inp_q <= '{default: '0};
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (wr_ctrl[i]) begin
          inp_q[i] <= wdata[CTSS_F_INP_LO+:IW];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fire command pulses and free-run frame timer
  wire free_run = !g_mod[CTSS_MOD_FRAME].ctrl_q[CTSS_F_EN];
  wire rate_hit = free_run && (rate_cnt_q >= rate_q - 32'h1);
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      sw_q <= 3'h0;
      rate_q <= CTSS_RATE_RST;
      rate_cnt_q <= 32'h0;
    end else if (ce) begin
      sw_q <= wr_fire ? wdata[2:0] : 3'h0;
      if (wr_rate) begin
        rate_q <= (wdata == 32'h0) ? 32'h1 : wdata;
      end
      if (!free_run || rate_hit) begin
        rate_cnt_q <= 32'h0;
      end else begin
        rate_cnt_q <= rate_cnt_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and trigger outputs
  logic [31:0] rd_mux;
  always_comb begin
    case (addr)
      CTSS_REG_CTRL0: rd_mux = ctrl_rd[0];
      CTSS_REG_CTRL1: rd_mux = ctrl_rd[1];
      CTSS_REG_CTRL2: rd_mux = ctrl_rd[2];
      CTSS_REG_STEP0: rd_mux = step_rd[0];
      CTSS_REG_STEP1: rd_mux = step_rd[1];
      CTSS_REG_STEP2: rd_mux = step_rd[2];
      CTSS_REG_ERR0: rd_mux = err_rd[0];
      CTSS_REG_ERR1: rd_mux = err_rd[1];
      CTSS_REG_ERR2: rd_mux = err_rd[2];
      CTSS_REG_RATE: rd_mux = rate_q;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      rdata <= 32'h0;
      trig <= 3'h0;
    end else if (ce) begin
      rdata <= rd ? rd_mux : 32'h0;
      trig <= {trig_d[2], trig_d[1] | (rate_hit & ready[1]), trig_d[0]};
    end
  end

endmodule : ctss_top
`default_nettype wire

// file: dv/ctss_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ctss_monitor
  import ctss_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [2:0] ready,
  input wire logic [2:0] trig
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Read port: data only after a read
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0) else $error("rdata not idle");
  a_hole_zero: assert property (rd && addr == 4'h3 |=> rdata == 32'h0) else $error("hole");
  // Source lists per module
  a_avail_burst: assert property (
    rd && addr == CTSS_REG_CTRL0 |=> rdata[20:16] == CTSS_AVAIL_BURST) else $error("mask 0");
  a_avail_frame: assert property (
    rd && addr == CTSS_REG_CTRL1 |=> rdata[20:16] == CTSS_AVAIL_FRAME) else $error("mask 1");
  a_avail_finish: assert property (
    rd && addr == CTSS_REG_CTRL2 |=> rdata[20:16] == CTSS_AVAIL_EXPEND) else $error("mask 2");
  // No trigger while a module is not ready
  a_burst_unready: assert property ((!ready[0])[*4] |-> !trig[0]) else $error("trig 0");
  a_frame_unready: assert property ((!ready[1])[*4] |-> !trig[1]) else $error("trig 1");
  a_finish_unready: assert property ((!ready[2])[*4] |-> !trig[2]) else $error("trig 2");
  // Main scenarios
  c_burst: cover property (trig[0]);
  c_frame: cover property (trig[1]);
  c_finish: cover property (trig[2]);
endmodule // ctss_monitor
bind ctss_top ctss_monitor u_mon (.clk(clk), .rst_n(rst_n), .addr(addr), .rd(rd),
  .rdata(rdata), .ready(ready), .trig(trig));
`default_nettype wire

// file: dv/ctss_far.sv
`timescale 1ns/10ps
`default_nettype none
module ctss_far (
  input wire logic clk,
  input wire logic pll_on,
  input wire logic enc_on,
  input wire logic enc_home,
  output logic pll_tick,
  output logic [31:0] enc_pos
);
  logic [2:0] div_q = 3'h0;
  logic tick_q = 1'b0;
  logic [31:0] pos_q = 32'h0;
  assign pll_tick = tick_q;
  assign enc_pos = pos_q;
  // Tick every eighth cycle, one encoder step per eight
  always @(posedge clk) begin
    div_q <= div_q + 3'h1;
    tick_q <= pll_on && div_q == 3'h7;
    pos_q <= enc_home ? 32'h0 : pos_q + 32'(enc_on && div_q == 3'h3);
  end
endmodule // ctss_far
`default_nettype wire

// file: dv/ctss_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ctss_top_tb
  import ctss_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pend = 1'b0;
  logic pll_on = 1'b0, enc_on = 1'b0, enc_home = 1'b0, pll_tick;
  logic [3:0] addr = 4'h0, ext_in = 4'h0;
  logic [2:0] ready = 3'h7, trig;
  logic [31:0] wdata = 32'h0, rdata, enc_pos;
  logic [31:0] m_q[$], e_q[$];
  int error_cnt = 0, n_checks = 0, nt = 0, r, s;
  int tc[3] = '{0, 0, 0};
  ctss_top dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ext_in(ext_in), .pll_tick(pll_tick), .enc_pos(enc_pos),
    .ready(ready), .trig(trig));
  ctss_far far (.clk(clk), .pll_on(pll_on), .enc_on(enc_on), .enc_home(enc_home),
    .pll_tick(pll_tick), .enc_pos(enc_pos));
  ////////////////////////////////////////
  // Clock and watchdog
  initial forever #20 clk = ~clk;
  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    m_q.push_back(m);
    e_q.push_back(e & m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic run_enc(input int t);
    @(posedge clk);
    enc_home <= 1'b1;
    @(posedge clk);
    enc_home <= 1'b0;
    enc_on <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 400 && enc_pos != 32'(t); i++) @(posedge clk);
    enc_on <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] tcs();
    return {8'h0, 8'(tc[2]), 8'(tc[1]), 8'(tc[0])};
  endfunction
  ////////////////////////////////////////
  // Pulse counters and read data scoreboard
  always @(negedge clk) begin
    for (int i = 0; i < 3; i++) tc[i] += int'(trig[i] === 1'b1);
    nt += int'(pll_tick === 1'b1);
    if (pend) chk("rdata", e_q.pop_front(), rdata & m_q.pop_front());
    pend = rd;
  end
  // Test sequence
  initial begin
    r = $urandom(77911);
    r = $urandom % 4;
    s = $urandom % 4 + 2;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Source lists, frame period, unmapped hole
    rchk(CTSS_REG_CTRL0, 32'h1F0000, {11'h0, CTSS_AVAIL_BURST, 16'h0});
    rchk(CTSS_REG_CTRL1, 32'h1F0000, {11'h0, CTSS_AVAIL_FRAME, 16'h0});
    rchk(CTSS_REG_CTRL2, 32'h1F0000, {11'h0, CTSS_AVAIL_EXPEND, 16'h0});
    rchk(CTSS_REG_RATE, 32'hFFFFFFFF, CTSS_RATE_RST);
    rchk(4'h3, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, CTSS_REG_RATE, 32'hA);
    // Host fire command, finish module lacks it
    for (int m = 0; m < 3; m++) bus(1'b1, 4'(m), 32'h11);
    tc = '{0, 0, 0};
    bus(1'b1, CTSS_REG_FIRE, 32'h7);
    repeat (5) @(posedge clk);
    chk("sw", 32'h000101, tcs());
    // Refused while not ready, ignored while disabled
    ready <= 3'h0;
    bus(1'b1, CTSS_REG_CTRL1, 32'h10);
    tc = '{0, 0, 0};
    bus(1'b1, CTSS_REG_FIRE, 32'h7);
    repeat (12) @(posedge clk);
    ready <= 3'h7;
    chk("off", 32'h0, tcs());
    rchk(CTSS_REG_ERR0, 32'hFFFF, 32'h1);
    rchk(CTSS_REG_ERR1, 32'hFFFF, 32'h0);
    // Rising edge, then falling edge with inversion
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, CTSS_REG_CTRL1, {22'h0, r[1:0], 8'h03} | (32'(i) << 2));
      bus(1'b1, CTSS_REG_CTRL2, {22'h0, r[1:0], 8'h01} | (32'(i) << 2));
      repeat (6) @(posedge clk);
      tc = '{0, 0, 0};
      ext_in <= 4'h1 << r;
      repeat (10) @(posedge clk);
      ext_in <= 4'h0;
      repeat (10) @(posedge clk);
      chk("ext", 32'h0A0100, tcs());
    end
    // Every multiplier tick fires the frame module
    bus(1'b1, CTSS_REG_CTRL1, 32'h21);
    tc = '{0, 0, 0};
    nt = 0;
    pll_on <= 1'b1;
    repeat (40) @(posedge clk);
    pll_on <= 1'b0;
    repeat (4) @(posedge clk);
    chk("pll", 32'(nt), 32'(tc[1]));
    // Periodic steps with a random interval, then single shot
    bus(1'b1, CTSS_REG_STEP0, 32'(s));
    bus(1'b1, CTSS_REG_CTRL0, 32'h31);
    tc = '{0, 0, 0};
    run_enc(20);
    chk("enc", 32'(20 / s), 32'(tc[0]));
    bus(1'b1, CTSS_REG_STEP0, 32'h6);
    bus(1'b1, CTSS_REG_CTRL0, 32'h41);
    run_enc(10);
    run_enc(10);
    chk("once", 32'(20 / s + 1), 32'(tc[0]));
    rchk(CTSS_REG_CTRL0, 32'h01000000, 32'h01000000);
    // Internal frame starts at the written period
    bus(1'b1, CTSS_REG_CTRL1, 32'h0);
    tc = '{0, 0, 0};
    repeat (100) @(posedge clk);
    chk("free", 32'h9, 32'(tc[1]));
    test_done();
  end
endmodule // ctss_top_tb
`default_nettype wire
